// >>> mem_map_pkg.sv
// Constants for the data space decoder, window, bank select and return stack
// Notes on behaviour
// - Program counter is 12 bits, 000h-FFFh
// - Six-entry 12-bit return stack
// - Data 40h-7Fh reads program memory bytes
// - Window moves in aligned 64-byte steps
// - Window address is base bits over offset
// - Window base is write only, no reads
// - Base uses bits 5-0, ignores 7-6
// - Data 00h-3Fh is banked RAM/EEPROM area
// - Pointers at 80h-81h, short direct 82h-83h
// - Sixty bytes general RAM at 84h-BFh
// - Accumulator is data location FFh
// - NMI vector FFCh, reset FFEh, others FF0h-FF6h
// - Readout protection blocks external program reads
// - Bank select E8h: bit4 RAM2, bit1/0 EEPROM
// - Bank select kept over calls and interrupts
package mem_map_pkg;
	localparam int PC_W          = 12;
	localparam int DATA_AW       = 8;
	localparam int STACK_DEPTH   = 6;
	localparam int WIN_OFS_W     = 6;
	localparam int WIN_BASE_W    = 6;
	localparam logic [7:0] BANK_LO        = 8'h00;
	localparam logic [7:0] BANK_HI        = 8'h3F;
	localparam logic [7:0] WIN_LO         = 8'h40;
	localparam logic [7:0] WIN_HI         = 8'h7F;
	localparam logic [7:0] ADDR_PTR_FIRST = 8'h80;
	localparam logic [7:0] ADDR_PTR_SECOND= 8'h81;
	localparam logic [7:0] ADDR_SD_FIRST  = 8'h82;
	localparam logic [7:0] ADDR_SD_SECOND = 8'h83;
	localparam logic [7:0] RAM_LO         = 8'h84;
	localparam logic [7:0] RAM_HI         = 8'hBF;
	localparam logic [7:0] ADDR_WIN_BASE  = 8'hC9;
	localparam logic [7:0] ADDR_BANK_SEL  = 8'hE8;
	localparam logic [7:0] ADDR_ACC       = 8'hFF;
	localparam logic [7:0] PERIPH_LO      = 8'hC0;
	// One bit per address C0h-FFh, set where the location is reserved
	localparam logic [63:0] RSVD_MAP      = 64'h7FFF_FAF8_C000_8C88;
	localparam int BANK_RAM2_BIT  = 4;
	localparam int BANK_EE1_BIT   = 1;
	localparam int BANK_EE0_BIT   = 0;
	localparam logic [11:0] VEC_IRQ_BASE  = 12'hFF0;
	localparam logic [11:0] VEC_NMI       = 12'hFFC;
	localparam logic [11:0] VEC_RESET     = 12'hFFE;
	localparam logic [7:0]  UNDEF_DATA    = 8'hFF;
	typedef enum logic [2:0] {
		REG_BANK, REG_WIN, REG_CORE, REG_RAM, REG_PERIPH, REG_NONE
	} region_t;
	typedef enum logic [1:0] {
		STK_NONE, STK_PUSH, STK_POP
	} stack_op_t;
endpackage

// >>> stack_if.sv
// Push/pop carrier between the decoder top and its return stack
`timescale 1ns/10ps
interface stack_if;
	import mem_map_pkg::*;
	logic              push;
	logic              pop;
	logic [PC_W-1:0]   push_addr;
	logic [PC_W-1:0]   top_addr;
	logic [2:0]        level;
	modport owner (output push, output pop, output push_addr, input top_addr, input level);
	modport stack (input push, input pop, input push_addr, output top_addr, output level);
endinterface

// >>> return_stack.sv
// Six-level return address stack, top entry read from a register
`timescale 1ns/10ps
module return_stack
	import mem_map_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
)(
	input  wire logic ref_clk_in,
	input  wire logic srst_in,
	stack_if.stack    stk
);
	logic [PC_W-1:0] mem_r [DEPTH];
	logic [2:0]      lvl_r;
	logic [PC_W-1:0] top_r;

	// Overflow drops the oldest entry, like a hardware stack with no trap
	always_ff @(posedge ref_clk_in)
	begin
		if (stk.push)
		begin
			for (int i = DEPTH-1; i > 0; i--)
				mem_r[i] <= mem_r[i-1];
			mem_r[0] <= stk.push_addr;
		end
		else if (stk.pop)
		begin
			for (int i = 0; i < DEPTH-1; i++)
				mem_r[i] <= mem_r[i+1];
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			lvl_r <= 3'h0;
		else if (stk.push && lvl_r != 3'(DEPTH))
			lvl_r <= lvl_r + 3'h1;
		else if (stk.pop && !stk.push && lvl_r != 3'h0)
			lvl_r <= lvl_r - 3'h1;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			top_r <= 12'h000;
		else if (stk.push)
			top_r <= stk.push_addr;
		else if (stk.pop)
			top_r <= mem_r[1];
	end

	assign stk.top_addr = top_r;
	assign stk.level    = lvl_r;

	a_stack_level_bound: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		lvl_r <= 3'(DEPTH)) else $error("stack level above depth");
	a_stack_push_top: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		stk.push |=> top_r == $past(stk.push_addr)) else $error("push not on top");
endmodule

// >>> data_space_decoder.sv
// Program counter, vectors, data space decode, window base and bank select
`timescale 1ns/10ps
module data_space_decoder
	import mem_map_pkg::*;
(
	input  wire logic               ref_clk_in,
	input  wire logic               srst_in,
	input  wire logic               pc_load_in,
	input  wire logic [PC_W-1:0]    pc_target_in,
	input  wire logic               pc_inc_in,
	input  wire logic               call_in,
	input  wire logic               ret_in,
	input  wire logic               nmi_take_in,
	input  wire logic               irq_take_in,
	input  wire logic [1:0]         irq_num_in,
	input  wire logic               data_rd_in,
	input  wire logic               data_wr_in,
	input  wire logic [DATA_AW-1:0] data_addr_in,
	input  wire logic [7:0]         data_wdata_in,
	input  wire logic [7:0]         prog_rdata_in,
	input  wire logic [7:0]         bank_rdata_in,
	input  wire logic [7:0]         ram_rdata_in,
	input  wire logic [7:0]         periph_rdata_in,
	input  wire logic               readout_protect_in,
	input  wire logic               ext_read_req_in,
	input  wire logic [PC_W-1:0]    ext_read_addr_in,
	output logic [PC_W-1:0]         pc_out,
	output logic [PC_W-1:0]         prog_addr_out,
	output logic [7:0]              data_rdata_out,
	output logic                    bank_ram2_sel_out,
	output logic                    bank_ee1_sel_out,
	output logic                    bank_ee0_sel_out,
	output logic                    bank_access_out,
	output logic                    ram_access_out,
	output logic                    periph_access_out,
	output logic                    ext_read_valid_out,
	output logic [7:0]              ext_read_data_out,
	output logic [2:0]              stack_level_out
);
	stack_if stk ();

	return_stack #(.DEPTH(STACK_DEPTH)) u_stack
	(
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.stk        (stk)
	);

	logic [PC_W-1:0]       pc_r;
	logic [PC_W-1:0]       pc_nxt;
	logic [WIN_BASE_W-1:0] win_base_r;
	logic [7:0]            bank_sel_r;
	logic [7:0]            ptr_first_r;
	logic [7:0]            ptr_second_r;
	logic [7:0]            sd_first_r;
	logic [7:0]            sd_second_r;
	logic [7:0]            acc_r;
	logic [7:0]            rdata_r;
	logic [PC_W-1:0]       prog_addr_r;
	logic                  ext_valid_r;
	logic [7:0]            ext_data_r;
	logic                  ext_pend_r;
	logic                  bank_acc_r;
	logic                  ram_acc_r;
	logic                  periph_acc_r;
	region_t               region;
	logic                  rd_pend_r;
	region_t               rd_region_r;
	logic [7:0]            core_rd;

	// Address region decode
	always_comb
	begin
		if (data_addr_in <= BANK_HI)
			region = REG_BANK;
		else if (data_addr_in <= WIN_HI)
			region = REG_WIN;
		else if (data_addr_in < RAM_LO)
			region = REG_CORE;
		else if (data_addr_in <= RAM_HI)
			region = REG_RAM;
		else if (data_addr_in == ADDR_ACC)
			region = REG_CORE;
		else if (data_addr_in >= PERIPH_LO)
			// Reserved holes get no peripheral strobe, so writes there do nothing
			region = RSVD_MAP[data_addr_in[5:0]] ? REG_NONE : REG_PERIPH;
		else
			region = REG_NONE;
	end

	// Next program counter, vectors first
	always_comb
	begin
		if (nmi_take_in)
			pc_nxt = VEC_NMI;
		else if (irq_take_in)
			pc_nxt = VEC_IRQ_BASE + PC_W'({irq_num_in, 1'b0});
		else if (ret_in)
			pc_nxt = stk.top_addr;
		else if (pc_load_in || call_in)
			pc_nxt = pc_target_in;
		else if (pc_inc_in)
			pc_nxt = pc_r + 12'h001;
		else
			pc_nxt = pc_r;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			pc_r <= VEC_RESET;
		else
			pc_r <= pc_nxt;
	end

	// Calls and taken interrupts save the return address
	assign stk.push      = !srst_in && (call_in || nmi_take_in || irq_take_in);
	assign stk.pop       = !srst_in && ret_in;
	assign stk.push_addr = pc_r + 12'h001;

	// Window base: no reset value on purpose, it is undefined until written
	always_ff @(posedge ref_clk_in)
	begin
		if (data_wr_in && data_addr_in == ADDR_WIN_BASE)
			win_base_r <= data_wdata_in[WIN_BASE_W-1:0];
	end

	// Bank select is only touched by writes, never by calls or interrupts
	always_ff @(posedge ref_clk_in)
	begin
		if (data_wr_in && data_addr_in == ADDR_BANK_SEL)
			bank_sel_r <= data_wdata_in;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (data_wr_in)
		begin
			case (data_addr_in)
				ADDR_PTR_FIRST:  ptr_first_r  <= data_wdata_in;
				ADDR_PTR_SECOND: ptr_second_r <= data_wdata_in;
				ADDR_SD_FIRST:   sd_first_r   <= data_wdata_in;
				ADDR_SD_SECOND:  sd_second_r  <= data_wdata_in;
				ADDR_ACC:        acc_r        <= data_wdata_in;
				default:         ;
			endcase
		end
	end

	always_comb
	begin
		case (data_addr_in)
			ADDR_PTR_FIRST:  core_rd = ptr_first_r;
			ADDR_PTR_SECOND: core_rd = ptr_second_r;
			ADDR_SD_FIRST:   core_rd = sd_first_r;
			ADDR_SD_SECOND:  core_rd = sd_second_r;
			ADDR_ACC:        core_rd = acc_r;
			default:         core_rd = UNDEF_DATA;
		endcase
	end

	// Program address mux: window reads use the current base, so a base write
	// is seen by the very next access with no wait added
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			prog_addr_r <= VEC_RESET;
		else if (data_rd_in && region == REG_WIN)
			prog_addr_r <= {win_base_r, data_addr_in[WIN_OFS_W-1:0]};
		else if (ext_read_req_in)
			prog_addr_r <= ext_read_addr_in;
		else
			prog_addr_r <= pc_nxt;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			rd_pend_r   <= 1'b0;
			rd_region_r <= REG_NONE;
		end
		else
		begin
			rd_pend_r   <= data_rd_in;
			rd_region_r <= region;
		end
	end

	// Read data return; window and bank data arrive one cycle after the address
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			rdata_r <= 8'h00;
		else if (data_rd_in && region == REG_CORE)
			rdata_r <= core_rd;
		else if (data_rd_in && region == REG_NONE)
			rdata_r <= UNDEF_DATA;
		else if (rd_pend_r)
		begin
			case (rd_region_r)
				REG_WIN:    rdata_r <= prog_rdata_in;
				REG_BANK:   rdata_r <= bank_rdata_in;
				REG_RAM:    rdata_r <= ram_rdata_in;
				REG_PERIPH: rdata_r <= periph_rdata_in;
				default:    ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			bank_acc_r   <= 1'b0;
			ram_acc_r    <= 1'b0;
			periph_acc_r <= 1'b0;
		end
		else
		begin
			bank_acc_r   <= (data_rd_in || data_wr_in) && region == REG_BANK;
			ram_acc_r    <= (data_rd_in || data_wr_in) && region == REG_RAM;
			periph_acc_r <= (data_rd_in || data_wr_in) && region == REG_PERIPH
				&& data_addr_in != ADDR_WIN_BASE && data_addr_in != ADDR_BANK_SEL;
		end
	end

	// External readout: blocked while protection is on
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			ext_pend_r  <= 1'b0;
			ext_valid_r <= 1'b0;
			ext_data_r  <= 8'h00;
		end
		else
		begin
			ext_pend_r  <= ext_read_req_in && !readout_protect_in
				&& !(data_rd_in && region == REG_WIN);
			ext_valid_r <= ext_pend_r;
			ext_data_r  <= ext_pend_r ? prog_rdata_in : 8'h00;
		end
	end

	assign pc_out             = pc_r;
	assign prog_addr_out      = prog_addr_r;
	assign data_rdata_out     = rdata_r;
	assign bank_ram2_sel_out  = bank_sel_r[BANK_RAM2_BIT];
	assign bank_ee1_sel_out   = bank_sel_r[BANK_EE1_BIT];
	assign bank_ee0_sel_out   = bank_sel_r[BANK_EE0_BIT];
	assign bank_access_out    = bank_acc_r;
	assign ram_access_out     = ram_acc_r;
	assign periph_access_out  = periph_acc_r;
	assign ext_read_valid_out = ext_valid_r;
	assign ext_read_data_out  = ext_data_r;
	assign stack_level_out    = stk.level;

	sequence s_win_read;
		data_rd_in && data_addr_in >= WIN_LO && data_addr_in <= WIN_HI;
	endsequence

	// External read that nothing blocks: protection off and no data read competing
	sequence s_ext_req;
		ext_read_req_in && !readout_protect_in && !data_rd_in;
	endsequence

	a_win_addr_form: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		s_win_read |=> prog_addr_r == {$past(win_base_r), $past(data_addr_in[5:0])})
		else $error("window address wrong");
	a_win_data_ret: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		s_win_read ##1 1'b1 |=> rdata_r == $past(prog_rdata_in))
		else $error("window data not returned");
	a_reset_vector: assert property (@(posedge ref_clk_in)
		srst_in |=> pc_r == VEC_RESET) else $error("reset vector wrong");
	a_nmi_vector: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		nmi_take_in |=> pc_r == VEC_NMI) else $error("nmi vector wrong");
	a_irq_vector: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		irq_take_in && !nmi_take_in |=> pc_r == VEC_IRQ_BASE + {$past(irq_num_in), 1'b0})
		else $error("irq vector wrong");
	a_protect_block: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		readout_protect_in |-> ##2 !ext_read_valid_out || $past(!readout_protect_in, 2))
		else $error("protected readout leaked");
	a_ext_read_ret: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		s_ext_req |-> ##2 ext_read_valid_out)
		else $error("unprotected readout lost");
	a_bank_keep: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(call_in || irq_take_in) && !data_wr_in |=> $stable(bank_sel_r))
		else $error("bank select changed on call");
	a_bank_route: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		data_wr_in && data_addr_in == ADDR_BANK_SEL |=>
		bank_ram2_sel_out == $past(data_wdata_in[4]))
		else $error("bank route wrong");
	a_ram_decode: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		data_rd_in && data_addr_in >= RAM_LO && data_addr_in <= RAM_HI |=> ram_access_out)
		else $error("ram not decoded");
	a_bank_decode: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		data_wr_in && data_addr_in <= BANK_HI |=> bank_access_out)
		else $error("bank not decoded");
	a_rsvd_read: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		data_rd_in && region == REG_NONE |=> rdata_r == UNDEF_DATA)
		else $error("reserved read value wrong");
	a_stack_pop_pc: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		ret_in && !nmi_take_in && !irq_take_in |=> pc_r == $past(stk.top_addr))
		else $error("return address wrong");
	a_pc_inc: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		pc_inc_in && !pc_load_in && !call_in && !ret_in && !nmi_take_in && !irq_take_in
		|=> pc_r == $past(pc_r) + 12'h001) else $error("pc increment wrong");
endmodule

// >>> mem_model.sv
// Memory side responder: program ROM plus bank, RAM and peripheral read ports
`timescale 1ns/10ps
module mem_model
	import mem_map_pkg::*;
(
	input  wire logic            ref_clk_in,
	input  wire logic            data_rd_in,
	input  wire logic [7:0]      data_addr_in,
	input  wire logic [PC_W-1:0] prog_addr_in,
	input  wire logic            bank_access_in,
	input  wire logic            ram_access_in,
	input  wire logic            periph_access_in,
	output logic      [7:0]      prog_rdata_out,
	output logic      [7:0]      bank_rdata_out,
	output logic      [7:0]      ram_rdata_out,
	output logic      [7:0]      periph_rdata_out
);
	logic [7:0] addr_r;
	logic       rsvd;

	always_ff @(posedge ref_clk_in)
		if (data_rd_in)
			addr_r <= data_addr_in;

	// Reserved program areas hold FFh
	assign rsvd = prog_addr_in < 12'h080 || (prog_addr_in >= 12'hFA0 && prog_addr_in < 12'hFF0);
	assign prog_rdata_out = rsvd ? 8'hFF : prog_addr_in[7:0] ^ {2{prog_addr_in[11:8]}};
	// Idle ports show the inverse so that a stale sample cannot pass
	assign bank_rdata_out   = bank_access_in ? 8'h3C ^ addr_r : ~(8'h3C ^ addr_r);
	assign ram_rdata_out    = ram_access_in ? 8'hA5 ^ addr_r : ~(8'hA5 ^ addr_r);
	assign periph_rdata_out = periph_access_in ? 8'hC3 ^ addr_r : ~(8'hC3 ^ addr_r);
endmodule

// >>> tb_top.sv
// Self-checking bench for the data space decoder
`timescale 1ns/10ps
module tb_top;
	import mem_map_pkg::*;
	typedef struct {int due; logic [7:0] val;} note_t;
	logic        ref_clk_in;
	logic        srst_in;
	logic [5:0]  ctl_v;
	logic        data_rd_in, data_wr_in, readout_protect_in, ext_read_req_in;
	logic [1:0]  irq_num_in;
	logic [11:0] pc_target_in, ext_read_addr_in, pc_out, prog_addr_out;
	logic [7:0]  data_addr_in, data_wdata_in, prog_rdata_in, bank_rdata_in;
	logic [7:0]  ram_rdata_in, periph_rdata_in, data_rdata_out, ext_read_data_out;
	logic        bank_ram2_sel_out, bank_ee1_sel_out, bank_ee0_sel_out;
	logic        bank_access_out, ram_access_out, periph_access_out, ext_read_valid_out;
	logic [2:0]  stack_level_out;
	int          cyc, bad_count, tests_run;
	note_t       q[$];
	note_t       eq[$];

	initial
	begin
		ref_clk_in = 1'b0;
		srst_in = 1'b1;
		{ctl_v, data_rd_in, data_wr_in, readout_protect_in, ext_read_req_in} = '0;
		{irq_num_in, pc_target_in, ext_read_addr_in, data_addr_in, data_wdata_in} = '0;
		{cyc, bad_count, tests_run} = '0;
	end
	always #5 ref_clk_in = ~ref_clk_in;

	data_space_decoder uut (.ref_clk_in, .srst_in, .pc_load_in(ctl_v[0]), .pc_target_in,
		.pc_inc_in(ctl_v[1]), .call_in(ctl_v[2]), .ret_in(ctl_v[3]), .nmi_take_in(ctl_v[4]),
		.irq_take_in(ctl_v[5]), .irq_num_in, .data_rd_in, .data_wr_in, .data_addr_in,
		.data_wdata_in, .prog_rdata_in, .bank_rdata_in, .ram_rdata_in, .periph_rdata_in,
		.readout_protect_in, .ext_read_req_in, .ext_read_addr_in, .pc_out, .prog_addr_out,
		.data_rdata_out, .bank_ram2_sel_out, .bank_ee1_sel_out, .bank_ee0_sel_out,
		.bank_access_out, .ram_access_out, .periph_access_out, .ext_read_valid_out,
		.ext_read_data_out, .stack_level_out);

	mem_model model (.ref_clk_in, .data_rd_in, .data_addr_in, .prog_addr_in(prog_addr_out),
		.bank_access_in(bank_access_out), .ram_access_in(ram_access_out),
		.periph_access_in(periph_access_out), .prog_rdata_out(prog_rdata_in),
		.bank_rdata_out(bank_rdata_in), .ram_rdata_out(ram_rdata_in),
		.periph_rdata_out(periph_rdata_in));

	function automatic logic [7:0] rom(input logic [11:0] a);
		if (a < 12'h080 || (a >= 12'hFA0 && a < 12'hFF0))
			return 8'hFF;
		return a[7:0] ^ {2{a[11:8]}};
	endfunction

	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t status got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_note(input note_t n, input logic [7:0] got);
		tests_run++;
		if (got !== n.val)
		begin
			bad_count++;
			$display("ERROR t=%0t read data got %h expected %h", $time, got, n.val);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One data cycle; a nonzero latency notes the byte expected back
	task automatic acc(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d,
		input int lat, input logic [7:0] exp);
		@(posedge ref_clk_in);
		data_rd_in <= rd;
		data_wr_in <= wr;
		data_addr_in <= a;
		data_wdata_in <= d;
		if (lat > 0)
			q.push_back('{cyc + lat, exp});
	endtask

	task automatic idle;
		@(posedge ref_clk_in);
		data_rd_in <= 1'b0;
		data_wr_in <= 1'b0;
		#1;
	endtask

	// Index: 0 load, 1 inc, 2 call, 3 ret, 4 nmi, 5 irq
	task automatic ctl(input int k, input logic [11:0] tgt, input logic [1:0] num);
		@(posedge ref_clk_in);
		ctl_v <= 6'h01 << k;
		pc_target_in <= tgt;
		irq_num_in <= num;
		@(posedge ref_clk_in);
		ctl_v <= 6'h00;
		@(posedge ref_clk_in);
		#1;
	endtask

	always @(posedge ref_clk_in)
	begin
		cyc <= cyc + 1;
		if (q.size() > 0 && q[0].due == cyc)
			chk_note(q.pop_front(), data_rdata_out);
		if (ext_read_valid_out === 1'b1)
			chk_note(eq.size() > 0 ? eq.pop_front() : note_t'{0, 8'hXX}, ext_read_data_out);
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk_in);
		bad_count++;
		end_of_test();
	end

	initial
	begin
		logic [7:0]  b, o, v;
		logic [11:0] pa;
		logic [7:0]  ra[6];
		logic [7:0]  rv[6];
		logic [7:0]  aa[5];
		logic [7:0]  ax[5];
		void'($urandom(32'h9084));
		ra = '{ADDR_PTR_FIRST, ADDR_PTR_SECOND, ADDR_SD_FIRST, ADDR_SD_SECOND, ADDR_ACC, 8'hC3};
		aa = '{8'h00, 8'h3F, 8'h84, 8'hBF, 8'hC0};
		ax = '{8'h3C, 8'h3C, 8'hA5, 8'hA5, 8'hC3};
		repeat (16) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		#1;
		cmp(pc_out, VEC_RESET);
		cmp(prog_addr_out, VEC_RESET);
		cmp(stack_level_out, 0);
		cmp(data_rdata_out, 0);
		$display("test reset done");
		// First pass is the worked mapping 59h with base 28h onto A19h
		for (int i = 0; i < 8; i++)
		begin
			b = i ? 8'($urandom) : 8'h28;
			o = i ? 8'($urandom) : 8'h19;
			pa = {b[5:0], o[5:0]};
			acc(0, 1, ADDR_WIN_BASE, b, 0, 0);
			acc(1, 0, WIN_LO | {2'b00, o[5:0]}, 0, 3, rom(pa));
			idle();
			cmp(prog_addr_out, pa);
		end
		$display("test window done");
		foreach (rv[i])
		begin
			rv[i] = 8'($urandom);
			acc(0, 1, ra[i], rv[i], 0, 0);
		end
		foreach (rv[i])
			acc(1, 0, ra[i], 0, 2, i == 5 ? UNDEF_DATA : rv[i]);
		idle();
		$display("test core registers done");
		foreach (ax[i])
		begin
			v = i < 2 ? 8'h10 << i : 8'h01 << (i - 2);
			acc(0, 1, ADDR_BANK_SEL, v, 0, 0);
			idle();
			cmp({bank_ram2_sel_out, bank_ee1_sel_out, bank_ee0_sel_out}, {v[4], v[1], v[0]});
		end
		foreach (aa[i])
			acc(1, 0, aa[i], 0, 3, ax[i] ^ aa[i]);
		idle();
		$display("test banked and RAM done");
		acc(0, 1, ADDR_BANK_SEL, 8'h10, 0, 0);
		idle();
		for (int k = 1; k <= 7; k++)
		begin
			ctl(2, 12'h100 + 12'(k), 0);
			cmp(pc_out, 12'h100 + 12'(k));
			cmp(stack_level_out, k > 6 ? 6 : k);
		end
		for (int k = 5; k >= 0; k--)
		begin
			ctl(3, 0, 0);
			cmp(stack_level_out, k);
			cmp(pc_out, 12'h102 + 12'(k));
		end
		ctl(4, 0, 0);
		cmp(pc_out, VEC_NMI);
		for (int n = 0; n < 4; n++)
		begin
			ctl(5, 0, 2'(n));
			cmp(pc_out, VEC_IRQ_BASE + 12'(2 * n));
		end
		ctl(0, 12'hFFF, 0);
		ctl(1, 0, 0);
		cmp(pc_out, 12'h000);
		cmp({bank_ram2_sel_out, bank_ee1_sel_out, bank_ee0_sel_out}, 3'b100);
		$display("test program counter done");
		for (int p = 0; p < 2; p++)
		begin
			pa = 12'($urandom);
			@(posedge ref_clk_in);
			readout_protect_in <= p[0];
			ext_read_req_in <= 1'b1;
			ext_read_addr_in <= pa;
			if (p == 0)
				eq.push_back('{0, rom(pa)});
			@(posedge ref_clk_in);
			ext_read_req_in <= 1'b0;
			repeat (4) @(posedge ref_clk_in);
		end
		$display("test external read done");
		for (int w = 0; w < 10 && q.size() > 0; w++)
			@(posedge ref_clk_in);
		if (q.size() > 0 || eq.size() > 0)
			bad_count++;
		end_of_test();
	end
endmodule
